// >>> tnoc_pkg.sv
package tnoc_pkg;

  // ---------------------------------------------------------------------------
  // register map (printed offsets are not word multiples: index, byte = 4*index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_NVM_CTRL   = 8'h33;
  localparam logic [7:0]  IDX_IF_OPT     = 8'h34;
  localparam logic [7:0]  IDX_OFFSET_COMP_CONTROL   = 8'h36;
  localparam logic [7:0]  IDX_OFC_SET    = 8'h37;
  localparam logic [7:0]  IDX_OFF_X      = 8'h38;
  localparam logic [7:0]  IDX_OFF_Y      = 8'h39;
  localparam logic [7:0]  IDX_OFF_Z      = 8'h3A;
  localparam logic [7:0]  IDX_NVM_CFG    = 8'h3D;  // nvm timing config, free slot

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int NVM_UNLOCK_BIT  = 0;
  localparam int NVM_PROG_BIT    = 1;
  localparam int NVM_RDY_BIT     = 2;
  localparam int NVM_LOAD_BIT    = 3;
  localparam int NVM_REMAIN_LSB  = 4;
  localparam int THREE_WIRE_BIT  = 0;
  localparam int WDT_SEL_BIT     = 1;
  localparam int WDT_EN_BIT      = 2;
  localparam int SLOW_EN_MSB     = 2;
  localparam int CAL_RDY_BIT     = 4;
  localparam int CAL_TRIG_LSB    = 5;
  localparam int OFF_CLEAR_BIT   = 7;

  // ---------------------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IF_OPT_MASK     = 8'h07;
  localparam logic [7:0]  OFC_SET_MASK    = 8'h7F;
  localparam logic [3:0]  NVM_REMAIN_RST  = 4'hF;
  localparam logic [7:0]  CFG_RST         = 8'h00;
  localparam logic [31:0] NVM_BUSY_CYC    = 32'h0000_0040;
  localparam logic [31:0] CAL_BUSY_CYC    = 32'h0000_0040;

  // ---------------------------------------------------------------------------
  // watchdog timing at 200 MHz
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int WDT_SHORT_MS = 1;
  localparam int WDT_LONG_MS  = 50;
  localparam int WDT_SHORT_CYC = WDT_SHORT_MS * CLK_MHZ * 1000;
  localparam int WDT_LONG_CYC  = WDT_LONG_MS * CLK_MHZ * 1000;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PROG} tnoc_nvm_st_type;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } tnoc_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } tnoc_apb_rsp_type;

  typedef struct packed {
    logic [7:0] offset_x;
    logic [7:0] offset_y;
    logic [7:0] offset_z;
    logic [2:0] slow_en;
    logic [6:0] offset_comp_setting;
    logic [2:0] if_opt;
  } tnoc_cfg_type;

endpackage : tnoc_pkg

// >>> tnoc_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module tnoc_regs (
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  input  wire tnoc_pkg::tnoc_apb_req_type apb_i,
  output tnoc_pkg::tnoc_apb_rsp_type      apb_o,
  input  wire logic                       two_wire_mode_i,
  input  wire logic                       serial_data_in_pin_i,
  input  wire tnoc_pkg::tnoc_cfg_type     nvm_image_i,
  input  wire logic [7:0]                 fast_result_i,
  input  wire logic [11:0]                accel_x_i,
  input  wire logic [11:0]                accel_y_i,
  input  wire logic [11:0]                accel_z_i,
  output tnoc_pkg::tnoc_cfg_type          cfg_o,
  output logic                            nvm_prog_pulse_o,
  output logic [1:0]                      fast_axis_o,
  output logic                            watchdog_expire_o,
  output logic [11:0]                     corr_x_o,
  output logic [11:0]                     corr_y_o,
  output logic [11:0]                     corr_z_o
);
  import tnoc_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    tnoc_apb_rsp_type rsp;
    tnoc_cfg_type     cfg;
    tnoc_nvm_st_type  nvm_st;
    logic [31:0]      nvm_cnt;
    logic             nvm_unlock;
    logic [3:0]       nvm_remain;
    logic             prog_pulse;
    logic [1:0]       cal_axis;
    logic [1:0]       cal_out;
    logic [31:0]      cal_cnt;
    logic [31:0]      wdt_cnt;
    logic             wdt_last;
    logic             wdt_exp;
    logic [11:0]      cx;
    logic [11:0]      cy;
    logic [11:0]      cz;
  } tnoc_state_type;

  tnoc_state_type s_reg;
  tnoc_state_type s_next;
  logic [7:0]     idx;
  logic           wr_acc;
  logic           rd_acc;
  logic [7:0]     wd;
  logic           nvm_rdy;
  logic           cal_rdy;
  logic [31:0]    wdt_limit;
  logic           take_wr;

  assign idx     = apb_i.paddr[9:2];
  assign wd      = apb_i.pwdata[7:0];
  assign wr_acc  = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd_acc  = apb_i.psel && apb_i.penable && !apb_i.pwrite;
  assign nvm_rdy = (s_reg.nvm_st == ST_IDLE);
  assign cal_rdy = (s_reg.cal_axis == 2'b00);
  assign take_wr = wr_acc && !s_reg.rsp.pready;                // write commits at this edge
  assign wdt_limit = s_reg.cfg.if_opt[WDT_SEL_BIT] ? 32'(WDT_LONG_CYC)
                                                   : 32'(WDT_SHORT_CYC);

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.prog_pulse = 1'b0;
    s_next.cal_out    = 2'b00;
    s_next.rsp.pready  = 1'b0;
    s_next.rsp.pslverr = 1'b0;
    s_next.rsp.prdata  = 32'h0000_0000;
    // nvm controller busy timing
    unique case (s_reg.nvm_st)
      ST_IDLE: ;
      ST_LOAD, ST_PROG: begin
        if (s_reg.nvm_cnt == 32'h0000_0000) begin
          s_next.nvm_st = ST_IDLE;
          if (s_reg.nvm_st == ST_LOAD) s_next.cfg = nvm_image_i;
        end else begin
          s_next.nvm_cnt = s_reg.nvm_cnt - 32'h0000_0001;
        end
      end
      default: s_next.nvm_st = ST_IDLE;                       // unused code recovers
    endcase
    // fast compensation runtime, result written into the axis offset
    if (!cal_rdy) begin
      if (s_reg.cal_cnt == 32'h0000_0000) begin
        unique case (s_reg.cal_axis)
          2'b01: s_next.cfg.offset_x = fast_result_i;
          2'b10: s_next.cfg.offset_y = fast_result_i;
          default: s_next.cfg.offset_z = fast_result_i;
        endcase
        s_next.cal_axis = 2'b00;
      end else begin
        s_next.cal_cnt = s_reg.cal_cnt - 32'h0000_0001;
      end
    end
    // apb access, one wait state: answer in the cycle after access starts
    if ((wr_acc || rd_acc) && !s_reg.rsp.pready) begin
      s_next.rsp.pready = 1'b1;
      unique case (idx)
        IDX_NVM_CTRL: begin
          s_next.rsp.prdata[7:0] = {s_reg.nvm_remain, 1'b0, nvm_rdy, 1'b0,
                                    s_reg.nvm_unlock};
          if (wr_acc) begin
            s_next.nvm_unlock = wd[NVM_UNLOCK_BIT];
            if (nvm_rdy && wd[NVM_LOAD_BIT]) begin
              s_next.nvm_st  = ST_LOAD;
              s_next.nvm_cnt = NVM_BUSY_CYC;
            end else if (nvm_rdy && wd[NVM_PROG_BIT] && s_reg.nvm_unlock &&
                         s_reg.nvm_remain != 4'h0) begin
              s_next.nvm_st     = ST_PROG;
              s_next.nvm_cnt    = NVM_BUSY_CYC;
              s_next.prog_pulse = 1'b1;
              s_next.nvm_remain = s_reg.nvm_remain - 4'h1;
            end
          end
        end
        IDX_IF_OPT: begin
          s_next.rsp.prdata[7:0] = {5'h00, s_reg.cfg.if_opt};
          if (wr_acc) s_next.cfg.if_opt = wd[2:0];
        end
        IDX_OFFSET_COMP_CONTROL: begin
          s_next.rsp.prdata[7:0] = {3'h0, cal_rdy, 1'b0, s_reg.cfg.slow_en};
          if (wr_acc) begin
            s_next.cfg.slow_en = wd[SLOW_EN_MSB:0];
            if (wd[OFF_CLEAR_BIT]) begin
              s_next.cfg.offset_x = 8'h00;
              s_next.cfg.offset_y = 8'h00;
              s_next.cfg.offset_z = 8'h00;
            end
            if (cal_rdy && wd[CAL_TRIG_LSB+:2] != 2'b00) begin
              s_next.cal_axis = wd[CAL_TRIG_LSB+:2];
              s_next.cal_out  = wd[CAL_TRIG_LSB+:2];
              s_next.cal_cnt  = CAL_BUSY_CYC;
            end
          end
        end
        IDX_OFC_SET: begin
          s_next.rsp.prdata[7:0] = {1'b0, s_reg.cfg.offset_comp_setting};
          if (wr_acc) s_next.cfg.offset_comp_setting = wd[6:0];
        end
        IDX_OFF_X: begin
          s_next.rsp.prdata[7:0] = s_reg.cfg.offset_x;
          if (wr_acc) s_next.cfg.offset_x = wd;
        end
        IDX_OFF_Y: begin
          s_next.rsp.prdata[7:0] = s_reg.cfg.offset_y;
          if (wr_acc) s_next.cfg.offset_y = wd;
        end
        IDX_OFF_Z: begin
          s_next.rsp.prdata[7:0] = s_reg.cfg.offset_z;
          if (wr_acc) s_next.cfg.offset_z = wd;
        end
        default: s_next.rsp.pslverr = 1'b1;                    // unmapped
      endcase
    end
    // two-wire watchdog: expires when data pin holds still too long
    s_next.wdt_last = serial_data_in_pin_i;
    s_next.wdt_exp  = 1'b0;
    if (!(two_wire_mode_i && s_reg.cfg.if_opt[WDT_EN_BIT]) ||
        serial_data_in_pin_i != s_reg.wdt_last) begin
      s_next.wdt_cnt = 32'h0000_0000;
    end else if (s_reg.wdt_cnt >= wdt_limit - 32'h0000_0001) begin
      s_next.wdt_exp = 1'b1;
      s_next.wdt_cnt = 32'h0000_0000;
    end else begin
      s_next.wdt_cnt = s_reg.wdt_cnt + 32'h0000_0001;
    end
    // offset subtraction, offset sign-extended to the 12-bit data width at the same lsb weight
    s_next.cx = accel_x_i - {{4{s_reg.cfg.offset_x[7]}}, s_reg.cfg.offset_x};
    s_next.cy = accel_y_i - {{4{s_reg.cfg.offset_y[7]}}, s_reg.cfg.offset_y};
    s_next.cz = accel_z_i - {{4{s_reg.cfg.offset_z[7]}}, s_reg.cfg.offset_z};
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg            <= '0;
      s_reg.nvm_remain <= NVM_REMAIN_RST;
      s_reg.nvm_st     <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_o             = s_reg.rsp;
  assign cfg_o             = s_reg.cfg;
  assign nvm_prog_pulse_o  = s_reg.prog_pulse;
  assign fast_axis_o       = s_reg.cal_out;
  assign watchdog_expire_o = s_reg.wdt_exp;
  assign corr_x_o          = s_reg.cx;
  assign corr_y_o          = s_reg.cy;
  assign corr_z_o          = s_reg.cz;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_nvm_prog_decr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.prog_pulse |-> s_reg.nvm_remain == $past(s_reg.nvm_remain) - 4'h1)
    else $error("remain count not decremented");
  chk_prog_needs_unlock: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.prog_pulse |-> $past(s_reg.nvm_unlock) && $past(s_reg.nvm_remain) != 4'h0)
    else $error("nvm write accepted while locked or exhausted");
  chk_nvm_busy_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.prog_pulse |-> !nvm_rdy [*8])
    else $error("nvm ready high during write");
  chk_offset_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_acc && !s_reg.rsp.pready && idx == IDX_OFFSET_COMP_CONTROL && wd[OFF_CLEAR_BIT] && cal_rdy)
    |=> s_reg.cfg.offset_x == 8'h00 && s_reg.cfg.offset_y == 8'h00 && s_reg.cfg.offset_z == 8'h00)
    else $error("offset clear failed");
  chk_cal_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fast_axis_o != 2'b00 |-> !cal_rdy ##1 !cal_rdy)
    else $error("fast ready high while running");
  chk_trig_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.prog_pulse |=> !s_reg.prog_pulse)
    else $error("trigger longer than one cycle");
  chk_wdt_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !s_reg.cfg.if_opt[WDT_EN_BIT] |=> !watchdog_expire_o)
    else $error("watchdog fired while disabled");
  chk_apb_answer: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_acc && idx == IDX_IF_OPT && !s_reg.rsp.pready) |=> apb_o.prdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");

  // ---------------------------------------------------------------------------
  // nvm controller checks
  // ---------------------------------------------------------------------------
  // remain count only moves on an accepted write
  chk_remain_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !s_reg.prog_pulse |-> s_reg.nvm_remain == $past(s_reg.nvm_remain))
    else $error("remain count moved without a write");
  // a locked control word never starts programming
  chk_prog_locked: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take_wr && idx == IDX_NVM_CTRL && !s_reg.nvm_unlock) |=> !s_reg.prog_pulse)
    else $error("nvm write started while locked");
  // reload bit clear: no reload starts
  chk_load_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take_wr && idx == IDX_NVM_CTRL && nvm_rdy && !wd[NVM_LOAD_BIT]) |=> s_reg.nvm_st != ST_LOAD)
    else $error("reload started without its bit");
  // reload completion copies the whole image unless a write or a fast compensation result lands
  chk_load_copy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_reg.nvm_st == ST_LOAD && s_reg.nvm_cnt == 32'h0000_0000 && cal_rdy && !take_wr)
    |=> s_reg.cfg == $past(nvm_image_i))
    else $error("reload did not copy the image");
  // ---------------------------------------------------------------------------
  // compensation and interface checks
  // ---------------------------------------------------------------------------
  // written trigger code shows as the axis pulse
  chk_cal_axis: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take_wr && idx == IDX_OFFSET_COMP_CONTROL && cal_rdy) |=> fast_axis_o == $past(wd[CAL_TRIG_LSB+:2]))
    else $error("fast trigger axis wrong");
  // ready returns when the runtime counter ends
  chk_cal_finish: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!cal_rdy && s_reg.cal_cnt == 32'h0000_0000) |=> cal_rdy)
    else $error("fast ready did not return");
  // slow enables follow the written bits
  chk_slow_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take_wr && idx == IDX_OFFSET_COMP_CONTROL) |=> s_reg.cfg.slow_en == $past(wd[SLOW_EN_MSB:0]))
    else $error("slow enables not written");
  // interface options follow the written bits
  chk_if_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (take_wr && idx == IDX_IF_OPT) |=> s_reg.cfg.if_opt == $past(wd[2:0]))
    else $error("interface options not written");
  // ---------------------------------------------------------------------------
  // watchdog checks
  // ---------------------------------------------------------------------------
  // counter held clear while watchdog is off
  chk_wdt_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(two_wire_mode_i && s_reg.cfg.if_opt[WDT_EN_BIT]) |=> s_reg.wdt_cnt == 32'h0000_0000)
    else $error("watchdog counted while off");
  // stable pin advances the counter by one
  chk_wdt_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (two_wire_mode_i && s_reg.cfg.if_opt[WDT_EN_BIT] &&
     serial_data_in_pin_i == s_reg.wdt_last && s_reg.wdt_cnt < wdt_limit - 32'h0000_0001)
    |=> s_reg.wdt_cnt == $past(s_reg.wdt_cnt) + 32'h0000_0001)
    else $error("watchdog count did not advance");

  cov_prog: cover property (@(posedge clk_i) disable iff (!nrst_i) s_reg.prog_pulse);
  cov_load: cover property (@(posedge clk_i) disable iff (!nrst_i) s_reg.nvm_st == ST_LOAD);
  cov_cal:  cover property (@(posedge clk_i) disable iff (!nrst_i) fast_axis_o == 2'b11);
  cov_wdt:  cover property (@(posedge clk_i) disable iff (!nrst_i) watchdog_expire_o);
  cov_clear: cover property (@(posedge clk_i) disable iff (!nrst_i)
    take_wr && idx == IDX_OFFSET_COMP_CONTROL && wd[OFF_CLEAR_BIT]);

endmodule : tnoc_regs

// >>> tnoc_regs_tb_top.sv
`timescale 1ns/1ps
module tnoc_regs_tb_top;
  import tnoc_pkg::*;
  // ---------------------------------------------------------------------------
  // signals, counters and model state
  // ---------------------------------------------------------------------------
  logic             clk_i    = 1'b0;
  logic             nrst_i   = 1'b0;
  tnoc_apb_req_type apb_i    = '0;
  tnoc_apb_rsp_type apb_o;
  tnoc_cfg_type     img      = '0;
  tnoc_cfg_type     cfg_o;
  logic             sdi_pin  = 1'b0;
  logic             two_wire = 1'b1;
  logic [7:0]       fres     = 8'h00;
  logic [11:0]      ax       = 12'h000;
  logic [11:0]      ay       = 12'h000;
  logic [11:0]      az       = 12'h000;
  logic [11:0]      cx, cy, cz;
  logic             prog_p, wdt_p;
  logic [1:0]       faxis;
  logic [1:0]       last_axis = 2'b00;
  logic [31:0]      rd;
  logic             err;
  logic [7:0]       off [3];
  int               failures   = 0;
  int               n_compared = 0;
  int               seed       = 37022;
  int               n_prog     = 0;
  int               n_fast     = 0;
  int               n_wdt      = 0;
  int               rem        = 15;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  tnoc_regs tnoc_regs_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
    .two_wire_mode_i(two_wire), .serial_data_in_pin_i(sdi_pin), .nvm_image_i(img),
    .fast_result_i(fres), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
    .cfg_o(cfg_o), .nvm_prog_pulse_o(prog_p), .fast_axis_o(faxis),
    .watchdog_expire_o(wdt_p), .corr_x_o(cx), .corr_y_o(cy), .corr_z_o(cz)
  );

  // pulse counters and a busy serial data pin
  always @(posedge clk_i) begin
    if (prog_p === 1'b1) n_prog++;
    if (wdt_p === 1'b1) n_wdt++;
    if (faxis !== 2'b00) begin
      n_fast++;
      last_axis = faxis;
    end
    sdi_pin <= 1'($random(seed));
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    $display("counts: %0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    apb_i.paddr   <= {22'h0, idx, 2'b00};
    apb_i.pwrite  <= wr;
    apb_i.pwdata  <= wd;
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (apb_o.pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      wrap_up();
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  // polls a ready bit until it reads high, up to 60 reads
  task automatic poll(input logic [7:0] idx, input int b);
    int k;
    for (k = 0; k < 60; k++) begin
      apb(1'b0, idx, 32'h0000_0000);
      if (rd[b] === 1'b1) break;
    end
    if (k == 60) begin
      failures++;
      wrap_up();
    end
  endtask : poll

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic       acc;
    int         i;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdchk(IDX_NVM_CTRL, 32'h0000_00F4);
    rdchk(IDX_IF_OPT, 32'h0000_0000);
    rdchk(IDX_OFFSET_COMP_CONTROL, 32'h0000_0010);
    rdchk(IDX_OFC_SET, 32'h0000_0000);
    apb(1'b0, 8'h35, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      two_wire <= v[7];  // random interface mode
      apb(1'b1, IDX_IF_OPT, {24'h0, v});
      rdchk(IDX_IF_OPT, {24'h0, v & IF_OPT_MASK});
      check({29'h0, cfg_o.if_opt}, {29'h0, v[2:0]});
      apb(1'b1, IDX_OFC_SET, {24'h0, v});
      rdchk(IDX_OFC_SET, {24'h0, v & OFC_SET_MASK});
      check({25'h0, cfg_o.offset_comp_setting}, {25'h0, v[6:0]});
      apb(1'b1, IDX_OFFSET_COMP_CONTROL, {28'h0, v[3:0]});
      rdchk(IDX_OFFSET_COMP_CONTROL, {27'h0, 2'b10, v[2:0]});
      check({29'h0, cfg_o.slow_en}, {29'h0, v[2:0]});
    end
    check(32'(n_fast), 32'h0000_0000);
    $display("test config done");
    apb(1'b1, IDX_NVM_CTRL, 32'h0000_0002);
    rdchk(IDX_NVM_CTRL, 32'h0000_00F4);
    check(32'(n_prog), 32'h0000_0000);
    apb(1'b1, IDX_NVM_CTRL, 32'h0000_0001);
    for (i = 0; i < 16; i++) begin
      poll(IDX_NVM_CTRL, NVM_RDY_BIT);
      apb(1'b1, IDX_NVM_CTRL, 32'h0000_0003);
      acc = (rem > 0);
      rem = rem - int'(acc);
      rdchk(IDX_NVM_CTRL, {24'h0, 4'(rem), 1'b0, ~acc, 2'b01});
      check(32'(n_prog), 32'(15 - rem));
    end
    poll(IDX_NVM_CTRL, NVM_RDY_BIT);
    $display("test nvm write done");
    img <= tnoc_cfg_type'(37'({$random(seed), $random(seed)}));
    apb(1'b1, IDX_NVM_CTRL, 32'h0000_0009);
    apb(1'b0, IDX_NVM_CTRL, 32'h0000_0000);
    check({31'h0, rd[NVM_RDY_BIT]}, 32'h0000_0000);
    poll(IDX_NVM_CTRL, NVM_RDY_BIT);
    check({8'h0, cfg_o[36:13]}, {8'h0, img[36:13]});
    check({19'h0, cfg_o[12:0]}, {19'h0, img[12:0]});
    $display("test reload done");
    for (i = 1; i < 4; i++) begin
      fres <= 8'($random(seed));
      poll(IDX_OFFSET_COMP_CONTROL, CAL_RDY_BIT);
      apb(1'b1, IDX_OFFSET_COMP_CONTROL, {24'h0, 1'b0, 2'(i), 5'h00});
      rdchk(IDX_OFFSET_COMP_CONTROL, 32'h0000_0000);
      check({30'h0, last_axis}, 32'(i));
      poll(IDX_OFFSET_COMP_CONTROL, CAL_RDY_BIT);
      off[i-1] = fres;
      rdchk(IDX_OFF_X + 8'(i - 1), {24'h0, off[i-1]});
    end
    check(32'(n_fast), 32'h0000_0003);
    ax <= 12'($random(seed));
    ay <= 12'($random(seed));
    az <= 12'($random(seed));
    repeat (3) @(posedge clk_i);
    check({20'h0, cx}, {20'h0, ax - {{4{off[0][7]}}, off[0]}});
    check({20'h0, cy}, {20'h0, ay - {{4{off[1][7]}}, off[1]}});
    check({20'h0, cz}, {20'h0, az - {{4{off[2][7]}}, off[2]}});
    $display("test fast compensation done");
    apb(1'b1, IDX_OFFSET_COMP_CONTROL, 32'h0000_0000);
    rdchk(IDX_OFF_Y, {24'h0, off[1]});
    v = 8'($random(seed));
    apb(1'b1, IDX_OFF_Z, {24'h0, v});
    rdchk(IDX_OFF_Z, {24'h0, v});
    apb(1'b1, IDX_OFFSET_COMP_CONTROL, 32'h0000_0080);
    for (i = 0; i < 3; i++) begin
      rdchk(IDX_OFF_X + 8'(i), 32'h0000_0000);
    end
    check(32'(n_wdt), 32'h0000_0000);
    $display("test offset clear done");
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
endmodule : tnoc_regs_tb_top
